// [hw/mhs_host_regs.sv]
// Host register bank: operand words, main status and interrupt flags
`default_nettype none
module mhs_host_regs #(
  parameter int AXES = mhs_pkg::NUM_AXES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_en,
  // Host register port
  input wire logic bus_8bit,
  input wire logic [2:0] reg_index,
  input wire logic byte_high,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  // Command decode from the command register path
  input wire logic cmd_strobe,
  input wire logic [1:0] cmd_axis,
  input wire logic [AXES-1:0] err_clear_cmd,
  // Motion core state
  input wire mhs_pkg::mhs_axis_t [AXES-1:0] axis_state,
  input wire mhs_pkg::mhs_events_t [AXES-1:0] axis_events,
  input wire logic [15:0] interrupt_enable_reg [AXES],
  input wire logic multichip_mode,
  input wire logic sub_chip_error,
  input wire logic interp_started,
  input wire logic [2:0] circle_quadrant,
  input wire logic [3:0] prebuffer_count,
  // Outputs
  output logic [31:0] operand,
  output logic [AXES-1:0] axis_error,
  output logic next_node_writable,
  output logic prebuffer_full,
  output logic irq_out_n
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] byte_merge(input logic [15:0] old,
    input logic [15:0] din, input logic is8, input logic hi);
    logic [15:0] r;
    r = old;
    if (!is8)
      r = din;
    else if (hi)
      r[15:8] = din[7:0];
    else
      r[7:0] = din[7:0];
    return r;
  endfunction : byte_merge

  function automatic logic [15:0] byte_clear_mask(input logic is8,
    input logic hi);
    logic [15:0] m;
    m = 16'hFFFF;
    if (is8)
      m = hi ? 16'hFF00 : 16'h00FF;
    return m;
  endfunction : byte_clear_mask

  // Narrow bus returns the selected byte in the low lane, upper lane zero
  function automatic logic [15:0] read_lane(input logic [15:0] word,
    input logic is8, input logic hi);
    logic [15:0] r;
    r = word;
    if (is8)
    begin
      if (hi)
        r = {8'h00, word[15:8]};
      else
        r = {8'h00, word[7:0]};
    end
    return r;
  endfunction : read_lane

  // Shared by the write, clear and read paths so their index sets agree
  function automatic logic index_hit(input logic [2:0] idx,
    input logic [2:0] want);
    return idx == want;
  endfunction : index_hit

  // ****************************************
  // Operand words, no reset
  // ****************************************
  logic [15:0] operand_low_word;
  logic [15:0] operand_high_word;
  logic [15:0] next_low;
  logic [15:0] next_high;
  logic wr_low;
  logic wr_high;

  always_comb
  begin
    wr_low = wr_strobe && index_hit(reg_index, mhs_pkg::IDX_OPERAND_LOW);
    wr_high = wr_strobe && index_hit(reg_index, mhs_pkg::IDX_OPERAND_HIGH);
    next_low = operand_low_word;
    next_high = operand_high_word;
    // Each half stored independently, so write order is irrelevant
    if (wr_low)
      next_low = byte_merge(operand_low_word, wr_data, bus_8bit,
        byte_high);
    if (wr_high)
      next_high = byte_merge(operand_high_word, wr_data, bus_8bit,
        byte_high);
  end

  // No reset here: contents are undefined until written
  always_ff @(posedge clock)
  begin
    if (clock_en)
    begin
      operand_low_word <= next_low;
      operand_high_word <= next_high;
    end
  end

  // Raw bits; consumers treat them as two's complement
  assign operand = {operand_high_word, operand_low_word};

  // ****************************************
  // Axis error bits and selected axis
  // ****************************************
  logic [AXES-1:0] err_sticky;
  logic [AXES-1:0] next_err;
  logic [1:0] sel_axis;
  logic [1:0] next_sel_axis;

  always_comb
  begin
    next_sel_axis = sel_axis;
    // Every command moves the selection, a no-operation one included
    if (cmd_strobe)
      next_sel_axis = cmd_axis;
    for (int a = 0; a < AXES; a++)
    begin
      next_err[a] = err_sticky[a];
      // Clear first so a fresh error in the same cycle wins
      if (err_clear_cmd[a] || axis_events[a].drive_start)
        next_err[a] = 1'b0;
      if (|axis_state[a].err_flags)
        next_err[a] = 1'b1;
    end
    // Sub-chip errors land on axis 0, the main axis of a multichip group
    if (multichip_mode && sub_chip_error)
      next_err[0] = 1'b1;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      err_sticky <= '0;
      sel_axis <= mhs_pkg::AXIS_RESET;
    end
    else if (clock_en)
    begin
      err_sticky <= next_err;
      sel_axis <= next_sel_axis;
    end
  end

  assign axis_error = err_sticky;

  // ****************************************
  // Interrupt factor flags per axis
  // ****************************************
  logic [15:0] interrupt_factor_flags [AXES];
  logic [15:0] next_flags [AXES];
  logic [15:0] factor_ev [AXES];
  logic [3:0] cmp_prev [AXES];
  logic [3:0] next_cmp_prev [AXES];
  logic flag_read;

  always_comb
  begin
    flag_read = rd_strobe && index_hit(reg_index, mhs_pkg::IDX_INT_FLAGS);
    for (int a = 0; a < AXES; a++)
    begin
      factor_ev[a] = '0;
      next_cmp_prev[a] = axis_events[a].compare_met;
      // Compare inputs are levels: only the unmet-to-met change counts
      factor_ev[a][3:0] = axis_events[a].compare_met & ~cmp_prev[a];
      factor_ev[a][4] = axis_events[a].drive_start;
      factor_ev[a][5] = axis_events[a].const_start;
      factor_ev[a][6] = axis_events[a].const_end;
      factor_ev[a][7] = axis_events[a].drive_end;
      factor_ev[a][8] = axis_events[a].home_done;
      factor_ev[a][9] = axis_events[a].timer_expired;
      factor_ev[a][10] = axis_events[a].split_rise;
      factor_ev[a][11] = axis_events[a].split_done;
      factor_ev[a][15:12] = axis_events[a].sync_action;
      next_flags[a] = interrupt_factor_flags[a];
      // Read clears only the byte read on a narrow bus
      if (flag_read && (sel_axis == a[1:0]))
        next_flags[a] = interrupt_factor_flags[a] &
          ~byte_clear_mask(bus_8bit, byte_high);
      // Set after clear: an event coincident with the read survives
      next_flags[a] = next_flags[a] |
        (factor_ev[a] & interrupt_enable_reg[a]);
    end
  end

  // Pending flags drop at reset so irq_out_n idles high
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int a = 0; a < AXES; a++)
      begin
        interrupt_factor_flags[a] <= mhs_pkg::FLAGS_RESET;
        cmp_prev[a] <= 4'h0;
      end
    end
    else if (clock_en)
    begin
      for (int a = 0; a < AXES; a++)
      begin
        interrupt_factor_flags[a] <= next_flags[a];
        cmp_prev[a] <= next_cmp_prev[a];
      end
    end
  end

  // One shared line: any pending flag on any axis holds it low
  always_comb
  begin
    irq_out_n = 1'b1;
    for (int a = 0; a < AXES; a++)
      if (|interrupt_factor_flags[a])
        irq_out_n = 1'b0;
  end

  // ****************************************
  // Main status and read data
  // ****************************************
  logic [15:0] main_status;
  logic [15:0] rd_word;
  logic [15:0] next_rd;

  always_comb
  begin
    main_status = '0;
    for (int a = 0; a < AXES; a++)
    begin
      main_status[mhs_pkg::POS_DRV + a] = axis_state[a].driving;
      main_status[mhs_pkg::POS_ERR + a] = err_sticky[a];
    end
    main_status[mhs_pkg::POS_QUAD +: 3] = circle_quadrant;
    main_status[mhs_pkg::POS_NEXT] = next_node_writable;
    main_status[mhs_pkg::POS_COUNT +: 4] = prebuffer_count;
    // Unmapped indices read back as zero
    rd_word = '0;
    if (index_hit(reg_index, mhs_pkg::IDX_MAIN_STATUS))
      rd_word = main_status;
    else if (index_hit(reg_index, mhs_pkg::IDX_INT_FLAGS))
      rd_word = interrupt_factor_flags[sel_axis];
    next_rd = rd_data;
    // Captured on the clearing edge, so the host sees what it cleared
    if (rd_strobe)
      next_rd = read_lane(rd_word, bus_8bit, byte_high);
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      rd_data <= 16'h0000;
    else if (clock_en)
      rd_data <= next_rd;
  end

  // Writable while count is 1..7 after interpolation starts
  assign next_node_writable = interp_started &&
    (prebuffer_count != 4'h0) &&
    (prebuffer_count <= mhs_pkg::COUNT_MAX_WRITABLE);
  // Host must hold off node writes while this is high
  assign prebuffer_full = (prebuffer_count >= mhs_pkg::COUNT_FULL);

endmodule : mhs_host_regs
`default_nettype wire

// [hw/mhs_pkg.sv]
// Package: register indices, field positions and carrier types for mhs
`default_nettype none
package mhs_pkg;
  localparam int NUM_AXES = 4;
  // Register indices on the device register port
  localparam logic [2:0] IDX_OPERAND_LOW = 3'h6;
  localparam logic [2:0] IDX_OPERAND_HIGH = 3'h7;
  localparam logic [2:0] IDX_MAIN_STATUS = 3'h0;
  localparam logic [2:0] IDX_INT_FLAGS = 3'h1;
  // Main status field positions
  localparam int POS_DRV = 0;
  localparam int POS_ERR = 4;
  localparam int POS_QUAD = 8;
  localparam int POS_NEXT = 11;
  localparam int POS_COUNT = 12;
  localparam logic [3:0] COUNT_FULL = 4'h8;
  localparam logic [3:0] COUNT_MAX_WRITABLE = 4'h7;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [1:0] AXIS_RESET = 2'h0;
  // Per-axis compare levels and event pulses from the motion core
  typedef struct packed {
    logic [3:0] compare_met;
    logic drive_start;
    logic const_start;
    logic const_end;
    logic drive_end;
    logic home_done;
    logic timer_expired;
    logic split_rise;
    logic split_done;
    logic [3:0] sync_action;
  } mhs_events_t;
  // Per-axis drive state from the motion core
  typedef struct packed {
    logic driving;
    logic [7:0] err_flags;
  } mhs_axis_t;
endpackage : mhs_pkg
`default_nettype wire

// [tb/mhs_host_model.sv]
// Host CPU model: register reads and writes on the bank's port
`default_nettype none
module mhs_host_model (
  // Clock
  input wire logic clock,
  // Register port
  output logic bus_8bit,
  output logic [2:0] reg_index,
  output logic byte_high,
  output logic wr_strobe,
  output logic rd_strobe,
  output logic [15:0] wr_data,
  input wire logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    bus_8bit = 1'b0;
    reg_index = 3'h5;
    byte_high = 1'b0;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    wr_data = 16'h0000;
  end
  // Byte reads of the flags clear one half each
  task automatic mode(input logic b);
    @(negedge clock);
    bus_8bit = b;
  endtask : mode
  task automatic wr(input logic [2:0] i, input logic h, input logic [15:0] d);
    @(negedge clock);
    reg_index = i;
    byte_high = h;
    wr_data = d;
    wr_strobe = 1'b1;
    @(negedge clock);
    wr_strobe = 1'b0;
    // Released data must not look like the last write
    wr_data = ~d;
  endtask : wr
  task automatic rd(input logic [2:0] i, input logic h, output logic [15:0] d);
    @(negedge clock);
    reg_index = i;
    byte_high = h;
    rd_strobe = 1'b1;
    @(negedge clock);
    rd_strobe = 1'b0;
    @(negedge clock);
    d = rd_data;
  endtask : rd
endmodule : mhs_host_model
`default_nettype wire

// [tb/mhs_host_regs_assertions.sv]
// Checker: port properties of the host register bank
`default_nettype none
module mhs_host_regs_chk #(
  parameter int AXES = mhs_pkg::NUM_AXES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Inputs watched
  input wire logic clock_en,
  input wire logic bus_8bit,
  input wire logic [2:0] reg_index,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [15:0] wr_data,
  input wire logic [AXES-1:0] err_clear_cmd,
  input wire mhs_pkg::mhs_axis_t [AXES-1:0] axis_state,
  input wire mhs_pkg::mhs_events_t [AXES-1:0] axis_events,
  input wire logic [15:0] interrupt_enable_reg [AXES],
  input wire logic multichip_mode,
  input wire logic sub_chip_error,
  input wire logic interp_started,
  input wire logic [2:0] circle_quadrant,
  input wire logic [3:0] prebuffer_count,
  // Outputs watched
  input wire logic [15:0] rd_data,
  input wire logic [31:0] operand,
  input wire logic [AXES-1:0] axis_error,
  input wire logic next_node_writable,
  input wire logic prebuffer_full,
  input wire logic irq_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  logic wr_go;
  logic rd_go;
  assign wr_go = wr_strobe && clock_en && !bus_8bit;
  assign rd_go = rd_strobe && clock_en && !bus_8bit;
  a_operand_low: assert property (
    wr_go && reg_index == 3'h6 |=> operand[15:0] == $past(wr_data))
    else $error("operand low word not taken");
  a_operand_high: assert property (
    wr_go && reg_index == 3'h7 |=> operand[31:16] == $past(wr_data))
    else $error("operand high word not taken");
  a_status_read: assert property (
    rd_go && reg_index == 3'h0 |=> rd_data[15:8] == {$past(prebuffer_count),
    $past(next_node_writable), $past(circle_quadrant)})
    else $error("status upper byte wrong");
  a_next_node: assert property (
    next_node_writable == (interp_started && prebuffer_count != 4'h0
    && prebuffer_count < 4'h8))
    else $error("next node flag wrong");
  a_buffer_full: assert property (
    prebuffer_full == (prebuffer_count == 4'h8))
    else $error("full flag wrong");
  a_err_set: assert property (
    clock_en && axis_state[1].err_flags != 8'h00 |=> axis_error[1])
    else $error("error bit not set");
  a_err_clear: assert property (
    clock_en && err_clear_cmd[1] && axis_state[1].err_flags == 8'h00
    |=> !axis_error[1])
    else $error("error bit not cleared");
  a_sub_chip: assert property (
    clock_en && multichip_mode && sub_chip_error |=> axis_error[0])
    else $error("sub chip error lost");
  a_irq_event: assert property (
    clock_en && axis_events[1].drive_start && interrupt_enable_reg[1][4]
    |=> !irq_out_n)
    else $error("irq not raised");
endmodule : mhs_host_regs_chk
bind mhs_host_regs mhs_host_regs_chk #(.AXES(AXES)) chk_inst (
  .clock, .resetn, .clock_en, .bus_8bit, .reg_index, .wr_strobe,
  .rd_strobe, .wr_data, .err_clear_cmd, .axis_state, .axis_events,
  .interrupt_enable_reg, .multichip_mode, .sub_chip_error,
  .interp_started, .circle_quadrant, .prebuffer_count, .rd_data,
  .operand, .axis_error, .next_node_writable, .prebuffer_full,
  .irq_out_n
);
`default_nettype wire

// [tb/tb.sv]
// Testbench: scenarios for the host register bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    n_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic cmd_strobe = 1'b0;
  logic [1:0] cmd_axis = 2'h0;
  logic [3:0] err_clr = 4'h0;
  mhs_pkg::mhs_axis_t [3:0] ast = '0;
  mhs_pkg::mhs_events_t [3:0] ev = '0;
  logic [15:0] ien [4] = '{16'hfeff, 16'hfeff, 16'hfeff, 16'hfeff};
  logic mc = 1'b0;
  logic sub = 1'b0;
  logic interp = 1'b0;
  logic [2:0] quad = 3'h5;
  logic [3:0] cnt = 4'h0;
  logic b8, bh, ws, rs;
  logic [2:0] idx;
  logic [15:0] wd, rdat, d;
  logic [31:0] operand;
  logic [3:0] axis_error;
  logic nw, full, irq_n;
  int n_errors = 0;
  int total_checks = 0;
  always #4 clock = ~clock;
  mhs_host_model mhs_host_model_inst (.clock(clock), .bus_8bit(b8),
    .reg_index(idx), .byte_high(bh), .wr_strobe(ws), .rd_strobe(rs),
    .wr_data(wd), .rd_data(rdat));
  mhs_host_regs mhs_host_regs_inst (.clock(clock), .resetn(resetn),
    .clock_en(ce), .bus_8bit(b8), .reg_index(idx), .byte_high(bh),
    .wr_strobe(ws), .rd_strobe(rs), .wr_data(wd), .rd_data(rdat),
    .cmd_strobe(cmd_strobe), .cmd_axis(cmd_axis), .err_clear_cmd(err_clr),
    .axis_state(ast), .axis_events(ev), .interrupt_enable_reg(ien),
    .multichip_mode(mc), .sub_chip_error(sub), .interp_started(interp),
    .circle_quadrant(quad), .prebuffer_count(cnt), .operand(operand),
    .axis_error(axis_error), .next_node_writable(nw),
    .prebuffer_full(full), .irq_out_n(irq_n));
  task automatic w(input logic [2:0] i, input logic h, input logic [15:0] v);
    mhs_host_model_inst.wr(i, h, v);
  endtask : w
  task automatic r(input logic [2:0] i, input logic h);
    mhs_host_model_inst.rd(i, h, d);
  endtask : r
  task automatic pulse(input logic [15:0] e);
    @(negedge clock);
    ev[1] = mhs_pkg::mhs_events_t'(e);
    @(negedge clock);
    ev[1] = mhs_pkg::mhs_events_t'(e & 16'hf000);
  endtask : pulse
  task automatic t_operand;
    w(3'h7, 1'b0, 16'hfffe);
    w(3'h6, 1'b0, 16'h8001);
    `CHK("operand", 32'hfffe_8001, operand)
    mhs_host_model_inst.mode(1'b1);
    w(3'h7, 1'b1, 16'h0004);
    w(3'h7, 1'b0, 16'h0003);
    w(3'h6, 1'b1, 16'h0002);
    w(3'h6, 1'b0, 16'h0001);
    mhs_host_model_inst.mode(1'b0);
    `CHK("operand8", 32'h0403_0201, operand)
    $display("done t_operand");
  endtask : t_operand
  task automatic t_freeze;
    ce = 1'b0;
    w(3'h6, 1'b0, 16'h1234);
    `CHK("frozen", 32'h0403_0201, operand)
    ce = 1'b1;
    $display("done t_freeze");
  endtask : t_freeze
  task automatic t_status;
    logic [15:0] st;
    ast[0].driving = 1'b1;
    ast[2].driving = 1'b1;
    for (int i = 0; i <= 8; i++)
    begin
      cnt = 4'(i);
      interp = (i != 3);
      r(3'h0, 1'b0);
      st = {cnt, interp && i > 0 && i < 8, quad, 4'h0, 4'h5};
      `CHK("status", st, d)
      `CHK("next", interp && i > 0 && i < 8, nw)
      `CHK("full", i == 8, full)
    end
    $display("done t_status");
  endtask : t_status
  task automatic t_error;
    @(negedge clock);
    ast[1].err_flags = 8'h40;
    @(negedge clock);
    ast[1].err_flags = 8'h00;
    mc = 1'b1;
    sub = 1'b1;
    @(negedge clock);
    mc = 1'b0;
    `CHK("err", 4'h3, axis_error)
    // Interpolation is stopped before the host clears its errors
    interp = 1'b0;
    err_clr = 4'h3;
    @(negedge clock);
    err_clr = 4'h0;
    `CHK("err_clr", 4'h0, axis_error)
    ast[1].err_flags = 8'h01;
    @(negedge clock);
    ast[1].err_flags = 8'h00;
    `CHK("err_again", 4'h2, axis_error)
    ev[1].drive_start = 1'b1;
    @(negedge clock);
    ev[1].drive_start = 1'b0;
    `CHK("err_start", 4'h0, axis_error)
    $display("done t_error");
  endtask : t_error
  task automatic t_irq;
    @(negedge clock);
    cmd_strobe = 1'b1;
    @(negedge clock);
    cmd_strobe = 1'b0;
    pulse(16'h2884);
    `CHK("irq_low", 1'b0, irq_n)
    r(3'h1, 1'b0);
    `CHK("flags_ax0", 16'h0000, d)
    cmd_axis = 2'h1;
    cmd_strobe = 1'b1;
    @(negedge clock);
    cmd_strobe = 1'b0;
    r(3'h1, 1'b0);
    `CHK("flags", 16'h4012, d)
    `CHK("irq_high", 1'b1, irq_n)
    pulse(16'h266b);
    r(3'h1, 1'b0);
    `CHK("flags2", 16'hb660, d)
    pulse(16'h2110);
    mhs_host_model_inst.mode(1'b1);
    r(3'h1, 1'b0);
    `CHK("flags_lo", 16'h0080, d)
    `CHK("irq_keep", 1'b0, irq_n)
    r(3'h1, 1'b1);
    `CHK("flags_hi", 16'h0008, d)
    `CHK("irq_end", 1'b1, irq_n)
    $display("done t_irq");
  endtask : t_irq
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial
  begin
    #20000;
    n_errors++;
    stop_test();
  end
  initial
  begin
    repeat (12) @(negedge clock);
    resetn = 1'b1;
    t_operand();
    t_freeze();
    t_status();
    t_error();
    t_irq();
    stop_test();
  end
endmodule : tb
`default_nettype wire
